// file: core/host_if_pkg.sv
// Purpose: shared types and constants of the host interface select block
// Assumes: core clock of 250 MHz
// Notes:   all timing counts derived here

package host_if_pkg;

   localparam int          CORE_CLK_MHZ     = 250;
   localparam int          SAMPLE_W         = 48;
   localparam int          BUF_DEPTH        = 32;
   localparam int          BUF_AW           = 5;
   localparam int          SYNC_W           = 9;
   localparam logic [4:0]  TARGET_ADDR_BASE = 5'h03;
   localparam logic [7:0]  SEQ_TICKS        = 8'h0a;
   localparam logic [7:0]  MEAS_OSC_TICKS   = 8'h20;
   localparam logic [5:0]  LAST_SPI_BIT     = 6'h2f;
   localparam logic [2:0]  LAST_I2C_BYTE    = 3'h5;
   localparam logic [3:0]  BYTE_BITS        = 4'h8;

   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } sample_t;

   typedef enum logic [2:0] {
      MODE_POWER_DOWN = 3'b001,
      MODE_SINGLE     = 3'b010,
      MODE_CONTINUOUS = 3'b100
   } op_mode_t;

   typedef enum logic [5:0] {
      I2C_IDLE    = 6'b000001,
      I2C_ADDR    = 6'b000010,
      I2C_ACK_OUT = 6'b000100,
      I2C_TX      = 6'b001000,
      I2C_ACK_IN  = 6'b010000,
      I2C_RX      = 6'b100000
   } i2c_state_t;

endpackage

// file: core/sync_pins.sv
// Purpose: two flop synchroniser for a group of levels
// Assumes: inputs are quasi static against core_clk
// Notes:   first stage feeds only the second

`timescale 1ns/10ps
`default_nettype none

module sync_pins #(
   parameter int          W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         core_clk, // core clock
   input  wire logic         reset,    // sync reset, high
   input  wire logic [W-1:0] async_in, // levels from outside
   output logic      [W-1:0] sync_out  // synchronised levels
);

   logic [W-1:0] meta_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         meta_q   <= RST;
         sync_out <= RST;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // sync_pins

`default_nettype wire

// file: core/result_buffer.sv
// Purpose: result store for measurement sets awaiting readout
// Assumes: push while full is dropped here, the caller need not refuse it
// Notes:   head word comes out of a register

`timescale 1ns/10ps
`default_nettype none

module result_buffer (
   input  wire logic                      core_clk, // core clock
   input  wire logic                      reset,    // sync reset, high
   input  wire logic                      push,     // write one set
   input  wire host_if_pkg::sample_t      wr_data,  // set to write
   input  wire logic                      pop,      // drop the head
   output host_if_pkg::sample_t           rd_data,  // head set, registered
   output logic                           empty,    // nothing stored
   output logic                           full      // all entries used
);

   localparam int AW = host_if_pkg::BUF_AW;

   host_if_pkg::sample_t mem [host_if_pkg::BUF_DEPTH];
   logic [AW-1:0]        wr_ptr_q;
   logic [AW-1:0]        rd_ptr_q;
   logic [AW-1:0]        rd_ptr_d;
   logic [AW:0]          count_q;
   logic                 do_push;
   logic                 do_pop;

   assign do_push  = push && !full;
   assign do_pop   = pop && !empty;
   assign rd_ptr_d = do_pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
   assign empty    = (count_q == '0);
   assign full     = count_q[AW];

   always_ff @(posedge core_clk) begin
      if (do_push) begin
         mem[wr_ptr_q] <= wr_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         wr_ptr_q <= do_push ? wr_ptr_q + 1'b1 : wr_ptr_q;
         rd_ptr_q <= rd_ptr_d;
         count_q  <= count_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   // write through when the new head is written this cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rd_data <= '0;
      end else if (do_push && wr_ptr_q == rd_ptr_d) begin
         rd_data <= wr_data;
      end else begin
         rd_data <= mem[rd_ptr_d];
      end
   end

endmodule // result_buffer

`default_nettype wire

// file: core/host_interface_select.sv
// Purpose: pin level host interface, I2C target or 4-wire SPI by select pin
// Assumes: select low only for a SPI frame and high between frames; SPI link clock is the pin
// Notes:   SPI link side runs on the serial clock, I2C target and rest on core_clk

`timescale 1ns/10ps
`default_nettype none

module host_interface_select (
   input  wire logic                  core_clk,               // core clock
   input  wire logic                  reset,                  // power-on reset
   input  wire logic                  ext_reset_n,            // reset pin
   input  wire logic                  spi_select_n,           // select pin
   input  wire logic                  spi_serial_clock_in,    // SCL or SPI clk
   input  wire logic                  sda_in,                 // data pin level
   output logic                       sda_out,                // data pin value
   output logic                       sda_oe,                 // data pin drive
   output logic                       so_out,                 // serial output
   output logic                       so_oe,                  // so drive enable
   output logic                       data_ready_n_od_out,    // ready pin value
   output logic                       data_ready_n_od_oe,     // ready pin drive
   input  wire logic                  target_addr_strap_bit0, // strap 0
   input  wire logic                  target_addr_strap_bit1, // strap 1
   input  wire logic                  measure_oscillator,     // measure osc
   input  wire logic                  sequencer_oscillator,   // sequencer osc
   input  wire host_if_pkg::sample_t  sensor_sample,          // raw result
   input  wire logic                  mode_write,             // mode strobe
   input  wire host_if_pkg::op_mode_t mode_value,             // mode to set
   input  wire logic                  noise_suppress_filter,  // filter enable
   output host_if_pkg::op_mode_t      op_mode,                // current mode
   output logic                       measure_busy,           // sensor running
   output logic                       buffer_overrun,         // set was lost
   output logic [7:0]                 host_write_data,        // I2C write byte
   output logic                       host_write_valid        // write strobe
);

   localparam logic [8:0] SYNC_RST = 9'h0f3;

   logic [8:0]           sync_s;
   logic                 rst_i;
   logic                 cs_n_s;
   logic                 scl_s;
   logic                 sda_s;
   logic                 mosc_s;
   logic                 sosc_s;
   logic                 done_tgl_s;
   logic                 done_tgl_q;
   logic                 rst_q;
   logic                 scl_prev_q;
   logic                 sda_prev_q;
   logic                 mosc_prev_q;
   logic                 sosc_prev_q;
   logic                 done_prev_q;
   logic [1:0]           strap_q;
   logic                 i2c_mode;
   host_if_pkg::sample_t head;
   host_if_pkg::sample_t hold_q;
   host_if_pkg::sample_t prev_q;
   host_if_pkg::sample_t push_data;
   logic                 buf_empty;
   logic                 buf_full;
   logic                 push;
   logic                 pop;

   // power-on or pin reset clear core_clk state; only power-on clears the synchroniser and done_tgl_q
   sync_pins #(.W(9), .RST(SYNC_RST)) u_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .async_in ({ext_reset_n, target_addr_strap_bit1,
                  target_addr_strap_bit0, spi_select_n,
                  spi_serial_clock_in, sda_in, measure_oscillator,
                  sequencer_oscillator, done_tgl_q}),
      .sync_out (sync_s)
   );

   assign rst_i      = reset || !sync_s[8];
   assign cs_n_s     = sync_s[5];
   assign scl_s      = sync_s[4];
   assign sda_s      = sync_s[3];
   assign mosc_s     = sync_s[2];
   assign sosc_s     = sync_s[1];
   assign done_tgl_s = sync_s[0];
   assign i2c_mode   = cs_n_s;

   always_ff @(posedge core_clk) begin
      if (rst_i) begin
         scl_prev_q  <= 1'b1;
         sda_prev_q  <= 1'b1;
         mosc_prev_q <= 1'b0;
         sosc_prev_q <= 1'b0;
         done_prev_q <= 1'b0;
      end else begin
         scl_prev_q  <= scl_s;
         sda_prev_q  <= sda_s;
         mosc_prev_q <= mosc_s;
         sosc_prev_q <= sosc_s;
         done_prev_q <= done_tgl_s;
      end
   end

   always_ff @(posedge core_clk) begin
      rst_q <= rst_i;
   end

   // straps caught while reset is held
   // one cycle more: synchroniser leaves reset showing its reset levels
   always_ff @(posedge core_clk) begin
      if (rst_i || rst_q) begin
         strap_q <= sync_s[7:6];
      end
   end

   // ---------------- sequencer and measurement ----------------
   logic [7:0] seq_cnt_q;
   logic [7:0] meas_cnt_q;
   logic       seq_tick;
   logic       meas_tick;
   logic       meas_start;
   logic       meas_done;

   // timing paced by the two oscillators
   assign seq_tick   = sosc_s && !sosc_prev_q;
   assign meas_tick  = mosc_s && !mosc_prev_q;
   assign meas_done  = measure_busy && meas_tick &&
                       meas_cnt_q == host_if_pkg::MEAS_OSC_TICKS;
   assign meas_start = !measure_busy &&
      ((op_mode == host_if_pkg::MODE_SINGLE) ||
       (op_mode == host_if_pkg::MODE_CONTINUOUS && seq_tick &&
        seq_cnt_q == host_if_pkg::SEQ_TICKS));

   always_ff @(posedge core_clk) begin
      if (rst_i) begin
         op_mode <= host_if_pkg::MODE_POWER_DOWN;
      end else if (mode_write) begin
         op_mode <= mode_value;
      end else if (op_mode == host_if_pkg::MODE_SINGLE && meas_start) begin
         op_mode <= host_if_pkg::MODE_POWER_DOWN;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst_i || op_mode != host_if_pkg::MODE_CONTINUOUS) begin
         seq_cnt_q <= '0;
      end else if (seq_tick) begin
         seq_cnt_q <= (seq_cnt_q == host_if_pkg::SEQ_TICKS) ? 8'h00
                                                            : seq_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst_i) begin
         measure_busy <= 1'b0;
         meas_cnt_q   <= '0;
      end else if (meas_start) begin
         measure_busy <= 1'b1;
         meas_cnt_q   <= '0;
      end else if (meas_done) begin
         measure_busy <= 1'b0;
      end else if (measure_busy && meas_tick) begin
         meas_cnt_q <= meas_cnt_q + 8'h01;
      end
   end

   // average with previous set only when enabled
   always_comb begin
      push_data = sensor_sample;
      if (noise_suppress_filter) begin
         push_data.x = 16'((17'(signed'(prev_q.x)) +
                            17'(signed'(sensor_sample.x))) >>> 1);
         push_data.y = 16'((17'(signed'(prev_q.y)) +
                            17'(signed'(sensor_sample.y))) >>> 1);
         push_data.z = 16'((17'(signed'(prev_q.z)) +
                            17'(signed'(sensor_sample.z))) >>> 1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst_i) begin
         prev_q <= '0;
      end else if (meas_done) begin
         prev_q <= sensor_sample;
      end
   end

   assign push = meas_done;

   // full buffer keeps older sets, newest one is lost
   always_ff @(posedge core_clk) begin
      if (rst_i) begin
         buffer_overrun <= 1'b0;
      end else if (push && buf_full) begin
         buffer_overrun <= 1'b1;
      end else if (mode_write) begin
         buffer_overrun <= 1'b0;
      end
   end

   result_buffer u_buf (
      .core_clk (core_clk),
      .reset    (rst_i),
      .push     (push),
      .wr_data  (push_data),
      .pop      (pop),
      .rd_data  (head),
      .empty    (buf_empty),
      .full     (buf_full)
   );

   // open-drain ready, pulled low while data waits
   assign data_ready_n_od_out = 1'b0;
   assign data_ready_n_od_oe  = !buf_empty;

   // head frozen while a SPI frame runs
   always_ff @(posedge core_clk) begin
      if (rst_i) begin
         hold_q <= '0;
      end else if (cs_n_s) begin
         hold_q <= head;
      end
   end

   // ---------------- I2C target ----------------
   host_if_pkg::i2c_state_t st_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shreg_q;
   logic [2:0] byte_idx_q;
   logic       rw_q;
   logic       sda_drv_q;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_c;
   logic       stop_c;
   logic       i2c_pop;
   logic [7:0] cur_byte;
   logic [6:0] my_addr;

   // oversampled edges cover all bus speed modes
   assign scl_rise = i2c_mode && scl_s && !scl_prev_q;
   assign scl_fall = i2c_mode && !scl_s && scl_prev_q;
   assign start_c  = i2c_mode && scl_s && scl_prev_q && sda_prev_q && !sda_s;
   assign stop_c   = i2c_mode && scl_s && scl_prev_q && !sda_prev_q && sda_s;
   // straps form the low address bits
   assign my_addr  = {host_if_pkg::TARGET_ADDR_BASE, strap_q};
   assign cur_byte = 8'(head >> (6'(host_if_pkg::LAST_I2C_BYTE - byte_idx_q)
                                 * 6'h08));
   assign i2c_pop  = st_q == host_if_pkg::I2C_ACK_IN && scl_rise &&
                     byte_idx_q == host_if_pkg::LAST_I2C_BYTE;

   // clock pin as SCL, data pin as open-drain SDA
   always_ff @(posedge core_clk) begin
      if (rst_i || !i2c_mode || start_c || stop_c) begin
         st_q       <= (start_c && !rst_i) ? host_if_pkg::I2C_ADDR
                                           : host_if_pkg::I2C_IDLE;
         bit_cnt_q  <= '0;
         byte_idx_q <= '0;
         sda_drv_q  <= 1'b0;
      end else if (scl_rise) begin
         unique case (st_q)
            host_if_pkg::I2C_ADDR, host_if_pkg::I2C_RX: begin
               bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            host_if_pkg::I2C_ACK_IN: begin
               byte_idx_q <= i2c_pop ? 3'h0 : byte_idx_q + 3'h1;
               if (sda_s) begin
                  st_q <= host_if_pkg::I2C_IDLE;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (st_q)
            host_if_pkg::I2C_ADDR: begin
               if (bit_cnt_q == host_if_pkg::BYTE_BITS) begin
                  if (shreg_q[7:1] == my_addr) begin
                     st_q      <= host_if_pkg::I2C_ACK_OUT;
                     sda_drv_q <= 1'b1;
                  end else begin
                     st_q <= host_if_pkg::I2C_IDLE;
                  end
               end
            end
            host_if_pkg::I2C_RX: begin
               if (bit_cnt_q == host_if_pkg::BYTE_BITS) begin
                  st_q      <= host_if_pkg::I2C_ACK_OUT;
                  sda_drv_q <= 1'b1;
               end
            end
            host_if_pkg::I2C_ACK_OUT: begin
               st_q      <= rw_q ? host_if_pkg::I2C_TX : host_if_pkg::I2C_RX;
               sda_drv_q <= rw_q && !cur_byte[7];
               bit_cnt_q <= rw_q ? 4'h1 : 4'h0;
            end
            host_if_pkg::I2C_TX: begin
               if (bit_cnt_q == host_if_pkg::BYTE_BITS) begin
                  st_q      <= host_if_pkg::I2C_ACK_IN;
                  sda_drv_q <= 1'b0;
               end else begin
                  sda_drv_q <= !cur_byte[3'(7 - bit_cnt_q)];
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
            end
            host_if_pkg::I2C_ACK_IN: begin
               st_q      <= host_if_pkg::I2C_TX;
               sda_drv_q <= !cur_byte[7];
               bit_cnt_q <= 4'h1;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst_i) begin
         shreg_q          <= '0;
         rw_q             <= 1'b0;
         host_write_data  <= '0;
         host_write_valid <= 1'b0;
      end else begin
         host_write_valid <= 1'b0;
         if (scl_rise && (st_q == host_if_pkg::I2C_ADDR ||
                          st_q == host_if_pkg::I2C_RX)) begin
            shreg_q <= {shreg_q[6:0], sda_s};
         end
         if (scl_fall && st_q == host_if_pkg::I2C_ADDR &&
             bit_cnt_q == host_if_pkg::BYTE_BITS) begin
            rw_q <= shreg_q[0];
         end
         if (scl_fall && st_q == host_if_pkg::I2C_RX &&
             bit_cnt_q == host_if_pkg::BYTE_BITS) begin
            host_write_data  <= shreg_q;
            host_write_valid <= 1'b1;
         end
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe  = i2c_mode && sda_drv_q;

   // ---------------- SPI link, serial clock domain ----------------
   logic [5:0] in_idx_q;
   logic [5:0] out_idx_q;
   logic       pop_req_q;

   // mode 3, count and sample on the rising edge
   always_ff @(posedge spi_serial_clock_in or posedge spi_select_n) begin
      if (spi_select_n) begin
         in_idx_q  <= '0;
         pop_req_q <= 1'b0;
      end else begin
         if (in_idx_q == 6'h00) begin
            pop_req_q <= sda_in;
         end
         if (in_idx_q <= host_if_pkg::LAST_SPI_BIT) begin
            in_idx_q <= in_idx_q + 6'h01;
         end
      end
   end

   always_ff @(posedge spi_serial_clock_in or posedge reset) begin
      if (reset) begin
         done_tgl_q <= 1'b0;
      end else if (!spi_select_n && pop_req_q &&
                   in_idx_q == host_if_pkg::LAST_SPI_BIT) begin
         done_tgl_q <= !done_tgl_q;
      end
   end

   // data changes on the falling edge
   always_ff @(negedge spi_serial_clock_in or posedge spi_select_n) begin
      if (spi_select_n) begin
         out_idx_q <= '0;
      end else begin
         out_idx_q <= in_idx_q;
      end
   end

   // push-pull only in a selected SPI frame
   assign so_oe  = !spi_select_n && !i2c_mode;
   assign so_out = (out_idx_q <= host_if_pkg::LAST_SPI_BIT) &&
                   hold_q[6'(host_if_pkg::LAST_SPI_BIT - out_idx_q)];

   assign pop = i2c_pop || (!i2c_mode && done_tgl_s != done_prev_q);

endmodule // host_interface_select

`default_nettype wire

// file: dv/host_if_checker.sv
// Purpose: port-level checks on the host interface select block
// Assumes: all checks run on core_clk
// Notes:   bound into every host_interface_select instance

`timescale 1ns/10ps
`default_nettype none

module host_if_checker (
   input wire logic                  core_clk,            // core clock
   input wire logic                  reset,               // power-on reset
   input wire logic                  ext_reset_n,         // reset pin
   input wire logic                  spi_select_n,        // select pin
   input wire logic                  sda_out,             // data pin value
   input wire logic                  sda_oe,              // data pin drive
   input wire logic                  so_oe,               // so drive
   input wire logic                  data_ready_n_od_out, // ready value
   input wire logic                  data_ready_n_od_oe,  // ready drive
   input wire logic                  mode_write,          // mode strobe
   input wire host_if_pkg::op_mode_t mode_value,          // mode to set
   input wire host_if_pkg::op_mode_t op_mode,             // current mode
   input wire logic                  measure_busy,        // sensor running
   input wire logic                  buffer_overrun       // set was lost
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset || !ext_reset_n);

   sequence s_single_go;
      op_mode == host_if_pkg::MODE_SINGLE
      ##1 (measure_busy && op_mode == host_if_pkg::MODE_POWER_DOWN);
   endsequence

   AST_RESET_STATE: assert property (
      $fell(reset) |-> op_mode == host_if_pkg::MODE_POWER_DOWN
      && !data_ready_n_od_oe && !measure_busy && !buffer_overrun)
      else $error("state after power-on reset wrong");
   AST_PIN_RESET: assert property (
      $rose(ext_reset_n) |-> ##2 (op_mode == host_if_pkg::MODE_POWER_DOWN
      && !data_ready_n_od_oe))
      else $error("state after pin reset wrong");
   AST_MODE_LOAD: assert property (
      mode_write |=> op_mode == $past(mode_value))
      else $error("mode not loaded");
   AST_SINGLE_START: assert property (
      mode_write && mode_value == host_if_pkg::MODE_SINGLE |=> s_single_go)
      else $error("single measurement did not start");
   AST_READY_AFTER_DONE: assert property (
      $fell(measure_busy) |-> ##[1:3] data_ready_n_od_oe)
      else $error("ready not raised after measurement");
   AST_READY_OD: assert property (
      data_ready_n_od_out == 1'b0)
      else $error("ready pin driven high");
   AST_SDA_OD: assert property (
      sda_out == 1'b0)
      else $error("data pin driven high");
   AST_SDA_QUIET: assert property (
      !spi_select_n [*4] |-> !sda_oe)
      else $error("data pin driven during SPI");
   AST_SO_RELEASE: assert property (
      spi_select_n |-> !so_oe)
      else $error("serial output driven while deselected");
   AST_SO_DRIVE: assert property (
      !spi_select_n [*4] |-> so_oe)
      else $error("serial output not driven in frame");
   AST_OVERRUN_STICKY: assert property (
      buffer_overrun && !mode_write |=> buffer_overrun)
      else $error("overrun flag lost");
endmodule // host_if_checker

bind host_interface_select host_if_checker i_chk (
   .core_clk(core_clk), .reset(reset), .ext_reset_n(ext_reset_n),
   .spi_select_n(spi_select_n), .sda_out(sda_out), .sda_oe(sda_oe),
   .so_oe(so_oe), .data_ready_n_od_out(data_ready_n_od_out),
   .data_ready_n_od_oe(data_ready_n_od_oe), .mode_write(mode_write),
   .mode_value(mode_value), .op_mode(op_mode),
   .measure_busy(measure_busy), .buffer_overrun(buffer_overrun));

`default_nettype wire

// file: dv/spi_host_model.sv
// Purpose: host side 4-wire SPI master, reads one result set a frame
// Assumes: 30 ns serial clock, free of core_clk phase
// Notes:   first data bit sent asks for a pop

`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
   output logic      select_n, // chip select, low active
   output logic      sck,      // serial clock
   output logic      si,       // data to device
   input  wire logic so,       // data from device
   input  wire logic sda       // data line level, pulled up
);
   initial begin
      select_n = 1'b1;
      sck = 1'b1;
      si = 1'b0;
   end

   task automatic frame(input logic pop, output host_if_pkg::sample_t got);
      got = '0;
      #7.3;
      select_n = 1'b0;
      for (int b = 0; b < 48; b++) begin
         // change on fall, sample on rise
         #15 sck = 1'b0;
         si = (b == 0) ? pop : ~si;
         #15 sck = 1'b1;
         got = {got[46:0], so};
      end
      #15 select_n = 1'b1;
      si = ~si;
   endtask

   // I2C write of two bytes, select stays high
   task automatic i2c_write(input logic [15:0] bytes,
                            output logic [1:0] nak);
      nak = 2'b11;
      si = 1'b1;
      #60 si = 1'b0;
      for (int b = 0; b < 18; b++) begin
         #30 sck = 1'b0;
         si = (b % 9 == 8) ? 1'b1 : bytes[15 - b + b / 9];
         #30 sck = 1'b1;
         if (b % 9 == 8) nak[b / 9] = sda;
      end
      #30 sck = 1'b0;
      si = 1'b0;
      #30 sck = 1'b1;
      #30 si = 1'b1;
   endtask
endmodule // spi_host_model

`default_nettype wire

// file: dv/compass_host_interface_select_tb.sv
// Purpose: self-checking bench for the host interface select block
// Assumes: I2C then SPI use, straps tied low
// Notes:   oscillator pins come from a core_clk counter

`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
$display("Error t=%0t got %h exp %h", $time, g, e); end end

module compass_host_interface_select_tb;
   logic                  core_clk = 1'b0;
   logic                  reset = 1'b1;
   logic                  ext_reset_n = 1'b1;
   logic                  mode_write = 1'b0;
   logic                  noise_suppress_filter = 1'b0;
   host_if_pkg::op_mode_t mode_value = host_if_pkg::MODE_POWER_DOWN;
   host_if_pkg::sample_t  sensor_sample = '0;
   host_if_pkg::sample_t  got;
   logic [7:0]            host_write_data;
   logic [1:0]            nak;
   host_if_pkg::op_mode_t op_mode;
   logic [7:0]            osc_q = 8'h00;
   logic                  spi_select_n, sck, si, sda_in, so_w;
   logic                  sda_out, sda_oe, so_out, so_oe, rdy_out;
   logic                  data_ready_n_od_oe, measure_busy, buffer_overrun;
   int                    err_count = 0;
   int                    num_checks = 0;

   assign sda_in = sda_oe ? 1'b0 : si;
   assign so_w = so_oe ? so_out : 1'bz;
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) osc_q <= osc_q + 8'h01;

   // straps tied low, I2C address is TARGET_ADDR_BASE with low bits 00
   host_interface_select i_dut (
      .core_clk(core_clk), .reset(reset), .ext_reset_n(ext_reset_n),
      .spi_select_n(spi_select_n), .spi_serial_clock_in(sck),
      .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
      .so_out(so_out), .so_oe(so_oe), .data_ready_n_od_out(rdy_out),
      .data_ready_n_od_oe(data_ready_n_od_oe),
      .target_addr_strap_bit0(1'b0), .target_addr_strap_bit1(1'b0),
      .measure_oscillator(osc_q[2]), .sequencer_oscillator(osc_q[4]),
      .sensor_sample(sensor_sample), .mode_write(mode_write),
      .mode_value(mode_value), .noise_suppress_filter(noise_suppress_filter),
      .op_mode(op_mode), .measure_busy(measure_busy),
      .buffer_overrun(buffer_overrun), .host_write_data(host_write_data),
      .host_write_valid());

   spi_host_model i_host (
      .select_n(spi_select_n), .sck(sck), .si(si), .so(so_w),
      .sda(sda_in));

   task automatic conclude();
      if (err_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic set_mode(input host_if_pkg::op_mode_t m);
      mode_value <= m;
      mode_write <= 1'b1;
      @(posedge core_clk);
      mode_write <= 1'b0;
   endtask

   task automatic measure(input host_if_pkg::sample_t s);
      sensor_sample <= s;
      set_mode(host_if_pkg::MODE_SINGLE);
      for (int n = 0; n < 20 && measure_busy !== 1'b1; n++)
         @(posedge core_clk);
      for (int n = 0; n < 2000 && measure_busy !== 1'b0; n++)
         @(posedge core_clk);
      repeat (4) @(posedge core_clk);
   endtask

   task automatic rd(input logic pop, input host_if_pkg::sample_t exp);
      repeat (4) @(posedge core_clk);
      i_host.frame(pop, got);
      `CHK(got, exp)
      repeat (6) @(posedge core_clk);
   endtask

   initial begin
      #400us;
      err_count++;
      conclude();
   end

   initial begin
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      repeat (25010) @(posedge core_clk);
      `CHK(op_mode, host_if_pkg::MODE_POWER_DOWN)
      `CHK(data_ready_n_od_oe, 1'b0)
      `CHK(so_oe, 1'b0)
      // select never toggled during the I2C part
      i_host.i2c_write({host_if_pkg::TARGET_ADDR_BASE, 3'h0, 8'h5a}, nak);
      `CHK(nak, 2'b00)
      `CHK(host_write_data, 8'h5a)
      i_host.i2c_write(16'h1aa5, nak);
      `CHK(nak, 2'b11)
      `CHK(host_write_data, 8'h5a)
      @(posedge core_clk);
      measure(48'h1234_8000_7ffe);
      `CHK(data_ready_n_od_oe, 1'b1)
      rd(1'b1, 48'h1234_8000_7ffe);
      `CHK(data_ready_n_od_oe, 1'b0)
      noise_suppress_filter <= 1'b1;
      measure(48'h0010_8002_fffc);
      // signed mean per axis, worked by hand
      rd(1'b0, 48'h0922_8001_3ffd);
      `CHK(data_ready_n_od_oe, 1'b1)
      rd(1'b1, 48'h0922_8001_3ffd);
      noise_suppress_filter <= 1'b0;
      for (int i = 0; i < 33; i++) begin
         measure({3{i[15:0]}});
         `CHK(buffer_overrun, i == 32)
      end
      for (int i = 0; i < 32; i++) begin
         `CHK(data_ready_n_od_oe, 1'b1)
         rd(1'b1, {3{i[15:0]}});
      end
      `CHK(data_ready_n_od_oe, 1'b0)
      set_mode(host_if_pkg::MODE_CONTINUOUS);
      repeat (1200) @(posedge core_clk);
      `CHK(op_mode, host_if_pkg::MODE_CONTINUOUS)
      `CHK(data_ready_n_od_oe, 1'b1)
      ext_reset_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      ext_reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      `CHK(op_mode, host_if_pkg::MODE_POWER_DOWN)
      `CHK(data_ready_n_od_oe, 1'b0)
      conclude();
   end
endmodule // compass_host_interface_select_tb

`default_nettype wire
